// ==== logic/prsr_pkg.sv ====
// Purpose: Shared constants and types of the pin reset and stop recovery sequencer
// Assumes: Single 250 MHz clock; watchdog oscillator arrives as a one-cycle tick
// Notes:   Register data is 8 bits wide, addresses are register indexes
package prsr_pkg;

    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 4;
    localparam int          CNT_W             = 10;
    localparam int          CLOCK_MHZ         = 250;

    // Register map
    localparam logic [3:0]  REG_WDCTL         = 4'h0;
    localparam logic [3:0]  REG_CTRL          = 4'h1;
    localparam logic [3:0]  REG_INT_STATUS    = 4'h2;
    localparam logic [3:0]  REG_INT_CLEAR     = 4'h3;
    localparam logic [3:0]  REG_INT_ENABLE    = 4'h4;
    localparam logic [3:0]  REG_SEQ_STATE     = 4'h5;

    // Watchdog control register flag positions
    localparam int          WD_STOP_BIT       = 0;
    localparam int          WD_TIMEOUT_BIT    = 1;
    localparam int          WD_EXT_BIT        = 2;
    localparam int          FLAG_W            = 3;

    // Control register and event positions
    localparam int          CTRL_IME_BIT      = 0;
    localparam int          EV_PIN_RESET      = 0;
    localparam int          EV_STOP_RECOVERY  = 1;
    localparam int          EV_WDT_WAKE       = 2;
    localparam int          EV_W              = 3;

    // Sequence lengths
    localparam int          WDO_HOLD_CYCLES   = 514;
    localparam int          SYS_HOLD_CYCLES   = 16;
    localparam int          SHORT_RST_CYCLES  = 66;

    // Reset vector locations and reset values
    localparam logic [15:0] VEC_ADDR_HI       = 16'h0002;
    localparam logic [15:0] VEC_ADDR_LO       = 16'h0003;
    localparam logic [7:0]  READ_ZERO         = 8'h00;
    localparam logic [2:0]  FLAGS_RESET       = 3'h0;

    typedef enum logic [3:0] {
        PRSR_SHORT_RST = 4'h0,
        PRSR_FETCH_HI  = 4'h1,
        PRSR_FETCH_LO  = 4'h3,
        PRSR_LOAD_PC   = 4'h2,
        PRSR_RUN       = 4'h6,
        PRSR_STOP      = 4'h7,
        PRSR_REC_WDO   = 4'h5,
        PRSR_REC_SYS   = 4'h4,
        PRSR_PIN_HOLD  = 4'h8
    } prsr_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } prsr_bus_req_t;

endpackage

// ==== logic/prsr_top.sv ====
// Purpose: Reset sequencing for the external reset pin and stop mode recovery
// Assumes: All inputs synchronous to clock; program memory answers one cycle after pm_rd
// Notes:   nrst is the power-on reset; the reset pin arrives on ext_reset_n
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module prsr_top
    import prsr_pkg::*;
#(
    parameter int GPIO_W        = 8,
    parameter int WDO_CYCLES    = WDO_HOLD_CYCLES,
    parameter int SYS_CYCLES    = SYS_HOLD_CYCLES,
    parameter int SHORT_CYCLES  = SHORT_RST_CYCLES
) (
    // Clock and power-on reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // External reset pin
    input  wire logic              ext_reset_n,
    // Core side
    input  wire logic              stop_instr,
    input  wire logic              core_ei,
    input  wire logic              core_di,
    input  wire logic              core_irq_ack,
    output logic                   core_reset,
    output logic                   regfile_reset,
    output logic                   stop_mode,
    output logic                   pc_load,
    output logic [15:0]            pc_value,
    output logic                   wdt_irq_req,
    // Program memory vector fetch
    output logic                   pm_rd,
    output logic [15:0]            pm_addr,
    input  wire logic [7:0]        pm_data,
    // Watchdog and wake sources
    input  wire logic              wdo_tick,
    input  wire logic              wdt_timeout,
    input  wire logic              wdt_irq_mode,
    input  wire logic [GPIO_W-1:0] gpio_in,
    input  wire logic [GPIO_W-1:0] gpio_wake_en,
    // Register port
    input  wire prsr_bus_req_t     bus_req,
    output logic [DATA_W-1:0]      rdata,
    output logic                   irq
);

    typedef struct packed {
        prsr_state_t         state;
        logic [CNT_W-1:0]    cnt;
        logic                cause_ext;
        logic                cause_stop;
        logic                cause_wdt;
        logic [7:0]          vec_hi;
        logic                core_reset;
        logic                regfile_reset;
        logic                stop_mode;
        logic                pc_load;
        logic [15:0]         pc_value;
        logic                wdt_irq_req;
        logic                pm_rd;
        logic [15:0]         pm_addr;
        logic [FLAG_W-1:0]   wdctl;
        logic                ime;
        logic [EV_W-1:0]     int_status;
        logic [EV_W-1:0]     int_enable;
        logic                irq;
        logic [DATA_W-1:0]   rdata;
        logic [GPIO_W-1:0]   gpio_prev;
    } prsr_st_t;

    localparam prsr_st_t RESET_ST = '{
        state:         PRSR_SHORT_RST,
        core_reset:    1'b1,
        regfile_reset: 1'b1,
        default:       '0
    };

    prsr_st_t st;
    prsr_st_t next_st;
    wire logic gpio_wake;

    function automatic logic cnt_done(input logic [CNT_W-1:0] cnt, input int limit);
        cnt_done = (cnt == CNT_W'(limit - 1));
    endfunction

    // Transition on any wake-enabled pin
    assign gpio_wake = |((gpio_in ^ st.gpio_prev) & gpio_wake_en);

    always_comb begin
        next_st = st;
        next_st.pc_load = 1'b0;
        next_st.rdata = READ_ZERO;
        next_st.gpio_prev = gpio_in;

        // Software writes; hardware sets below override a clear in the same cycle
        if (bus_req.wr) begin
            case (bus_req.addr)
                REG_WDCTL:      next_st.wdctl = st.wdctl & ~bus_req.wdata[FLAG_W-1:0];
                REG_CTRL:       next_st.ime = bus_req.wdata[CTRL_IME_BIT];
                REG_INT_CLEAR:  next_st.int_status = st.int_status & ~bus_req.wdata[EV_W-1:0];
                REG_INT_ENABLE: next_st.int_enable = bus_req.wdata[EV_W-1:0];
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                REG_WDCTL:      next_st.rdata = {5'h00, st.wdctl};
                REG_CTRL:       next_st.rdata = {7'h00, st.ime};
                REG_INT_STATUS: next_st.rdata = {5'h00, st.int_status};
                REG_INT_ENABLE: next_st.rdata = {5'h00, st.int_enable};
                REG_SEQ_STATE:  next_st.rdata = {4'h0, st.state};
                default:        next_st.rdata = READ_ZERO;
            endcase
        end

        // Master enable follows the core's enable, disable and acknowledge
        if (core_ei) begin
            next_st.ime = 1'b1;
        end
        if (core_di || core_irq_ack) begin
            next_st.ime = 1'b0;
        end
        if (core_irq_ack) begin
            next_st.wdt_irq_req = 1'b0;
        end

        case (st.state)
            PRSR_SHORT_RST: begin
                if (cnt_done(st.cnt, SHORT_CYCLES)) begin
                    next_st.cnt = '0;
                    if (ext_reset_n) begin
                        next_st.state = PRSR_FETCH_HI;
                        next_st.pm_rd = 1'b1;
                        next_st.pm_addr = VEC_ADDR_HI;
                    end else begin
                        next_st.state = PRSR_PIN_HOLD;
                    end
                end else begin
                    next_st.cnt = st.cnt + CNT_W'(1);
                end
            end
            PRSR_PIN_HOLD: begin
                if (ext_reset_n) begin
                    next_st.state = PRSR_FETCH_HI;
                    next_st.pm_rd = 1'b1;
                    next_st.pm_addr = VEC_ADDR_HI;
                end
            end
            PRSR_FETCH_HI: begin
                next_st.state = PRSR_FETCH_LO;
                next_st.pm_addr = VEC_ADDR_LO;
            end
            PRSR_FETCH_LO: begin
                next_st.state = PRSR_LOAD_PC;
                next_st.vec_hi = pm_data;
                next_st.pm_rd = 1'b0;
                next_st.pm_addr = '0;
            end
            PRSR_LOAD_PC: begin
                next_st.state = PRSR_RUN;
                next_st.pc_value = {st.vec_hi, pm_data};
                next_st.pc_load = 1'b1;
                next_st.core_reset = 1'b0;
                next_st.regfile_reset = 1'b0;
                if (st.cause_ext) begin
                    next_st.wdctl[WD_EXT_BIT] = 1'b1;
                    next_st.int_status[EV_PIN_RESET] = 1'b1;
                end
                if (st.cause_stop) begin
                    next_st.wdctl[WD_STOP_BIT] = 1'b1;
                    next_st.int_status[EV_STOP_RECOVERY] = 1'b1;
                end
                if (st.cause_wdt) begin
                    next_st.wdctl[WD_TIMEOUT_BIT] = 1'b1;
                    next_st.int_status[EV_WDT_WAKE] = 1'b1;
                    // Request only once the sequence is complete
                    if (wdt_irq_mode && next_st.ime) begin
                        next_st.wdt_irq_req = 1'b1;
                    end
                end
                next_st.cause_ext = 1'b0;
                next_st.cause_stop = 1'b0;
                next_st.cause_wdt = 1'b0;
            end
            PRSR_RUN: begin
                if (stop_instr) begin
                    next_st.state = PRSR_STOP;
                    next_st.stop_mode = 1'b1;
                end
            end
            PRSR_STOP: begin
                // Nothing but these sources or the reset pin ends stop
                if (wdt_timeout || gpio_wake) begin
                    next_st.state = PRSR_REC_WDO;
                    next_st.cnt = '0;
                    next_st.stop_mode = 1'b0;
                    next_st.core_reset = 1'b1;
                    next_st.cause_stop = 1'b1;
                    next_st.cause_wdt = wdt_timeout;
                end
            end
            PRSR_REC_WDO: begin
                if (wdo_tick) begin
                    if (cnt_done(st.cnt, WDO_CYCLES)) begin
                        next_st.state = PRSR_REC_SYS;
                        next_st.cnt = '0;
                    end else begin
                        next_st.cnt = st.cnt + CNT_W'(1);
                    end
                end
            end
            PRSR_REC_SYS: begin
                if (cnt_done(st.cnt, SYS_CYCLES)) begin
                    next_st.state = PRSR_FETCH_HI;
                    next_st.cnt = '0;
                    next_st.pm_rd = 1'b1;
                    next_st.pm_addr = VEC_ADDR_HI;
                end else begin
                    next_st.cnt = st.cnt + CNT_W'(1);
                end
            end
            default: begin
                next_st.state = PRSR_SHORT_RST;
                next_st.cnt = '0;
            end
        endcase

        // Reset pin takes over from any state; counting already under way continues
        if (!ext_reset_n) begin
            next_st.cause_ext = 1'b1;
            if (st.state != PRSR_SHORT_RST && st.state != PRSR_PIN_HOLD) begin
                next_st.state = PRSR_SHORT_RST;
                next_st.cnt = '0;
                next_st.core_reset = 1'b1;
                next_st.regfile_reset = 1'b1;
                next_st.stop_mode = 1'b0;
                next_st.pc_load = 1'b0;
                next_st.pm_rd = 1'b0;
                next_st.pm_addr = '0;
                next_st.wdt_irq_req = 1'b0;
                next_st.ime = 1'b0;
                next_st.cause_stop = 1'b0;
                next_st.cause_wdt = 1'b0;
            end
        end

        next_st.irq = |(next_st.int_status & next_st.int_enable);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign core_reset    = st.core_reset;
    assign regfile_reset = st.regfile_reset;
    assign stop_mode     = st.stop_mode;
    assign pc_load       = st.pc_load;
    assign pc_value      = st.pc_value;
    assign wdt_irq_req   = st.wdt_irq_req;
    assign pm_rd         = st.pm_rd;
    assign pm_addr       = st.pm_addr;
    assign rdata         = st.rdata;
    assign irq           = st.irq;

    property p_pin_start;
        @(posedge clock) disable iff (!nrst)
        (!ext_reset_n && st.state == PRSR_RUN) |=> (st.state == PRSR_SHORT_RST && core_reset);
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin low did not start reset");

    property p_pin_hold;
        @(posedge clock) disable iff (!nrst)
        (!ext_reset_n) |=> (core_reset && !pc_load);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("core left reset with pin low");

    property p_pin_release;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_PIN_HOLD && ext_reset_n) |=> (st.state == PRSR_FETCH_HI) ##3 pc_load;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("late release was delayed");

    property p_ext_flag;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_LOAD_PC && st.cause_ext) |=> st.wdctl[WD_EXT_BIT];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external reset flag not set");

    property p_stop_entry;
        @(posedge clock) disable iff (!nrst)
        $rose(stop_mode) |-> ($past(stop_instr) && $past(st.state) == PRSR_RUN);
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop entered without instruction");

    property p_wdo_hold;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_REC_WDO && !(wdo_tick && cnt_done(st.cnt, WDO_CYCLES)) && ext_reset_n)
        |=> (st.state == PRSR_REC_WDO);
    endproperty
    a_wdo_hold: assert property (p_wdo_hold) else $error("oscillator hold ended early");

    property p_sys_hold;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_REC_WDO ##1 st.state == PRSR_REC_SYS) |->
        (st.cnt == '0) and ((st.state == PRSR_REC_SYS && ext_reset_n)[*8] |->
        (st.cnt == CNT_W'(7)));
    endproperty
    a_sys_hold: assert property (p_sys_hold) else $error("system clock hold miscounted");

    property p_sys_end;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_REC_SYS ##1 st.state == PRSR_FETCH_HI) |->
        $past(st.cnt) == CNT_W'(SYS_CYCLES - 1);
    endproperty
    a_sys_end: assert property (p_sys_end) else $error("released before sixteen clocks");

    property p_regfile_kept;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_STOP && ext_reset_n) |=> !regfile_reset;
    endproperty
    a_regfile_kept: assert property (p_regfile_kept) else $error("stop recovery reset regs");

    property p_vector;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_FETCH_HI && ext_reset_n) |->
        (pm_rd && pm_addr == VEC_ADDR_HI) ##1 (pm_rd && pm_addr == VEC_ADDR_LO);
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch address wrong");

    property p_pc_load;
        @(posedge clock) disable iff (!nrst)
        pc_load |-> (pc_value == {$past(st.vec_hi), $past(pm_data)} && !core_reset);
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("program counter load wrong");

    property p_stop_flag;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_STOP && gpio_wake && ext_reset_n) |=>
        (st.state == PRSR_REC_WDO && st.cause_stop);
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("gpio wake not taken");

    property p_wdt_wake;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_LOAD_PC && st.cause_wdt && ext_reset_n) |=>
        (st.wdctl[WD_TIMEOUT_BIT] && st.wdctl[WD_STOP_BIT]);
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("timeout flags not set");

    property p_irq_after;
        @(posedge clock) disable iff (!nrst)
        $rose(wdt_irq_req) |-> (pc_load && st.ime && $past(st.cause_wdt) && $past(wdt_irq_mode));
    endproperty
    a_irq_after: assert property (p_irq_after) else $error("irq request out of sequence");

    property p_stay_stop;
        @(posedge clock) disable iff (!nrst)
        (st.state == PRSR_STOP && !wdt_timeout && !gpio_wake && ext_reset_n) |=>
        (st.state == PRSR_STOP && stop_mode);
    endproperty
    a_stay_stop: assert property (p_stay_stop) else $error("stop left without a source");

endmodule
`default_nettype wire

// ==== verification/prsr_pm_model.sv ====
// Purpose: Program memory model that answers the reset vector fetch
// Assumes: Data appear in the cycle after the address, like a registered read
// Notes:   Cycles without a vector read show a changing pattern, never stale data
`timescale 1ns/100ps
`default_nettype none
module prsr_pm_model
    import prsr_pkg::*;
#(
    parameter logic [15:0] VECTOR = 16'h3C5A
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Read port
    input  wire logic        pm_rd,
    input  wire logic [15:0] pm_addr,
    output logic [7:0]       pm_data
);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pm_data <= 8'hA5;
        end else if (pm_rd && pm_addr == VEC_ADDR_HI) begin
            pm_data <= VECTOR[15:8];
        end else if (pm_rd && pm_addr == VEC_ADDR_LO) begin
            pm_data <= VECTOR[7:0];
        end else begin
            pm_data <= ~pm_data;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_prsr_top.sv ====
// Purpose: Self-checking bench of the pin reset and stop recovery sequencer
// Assumes: Shortened counts 4, 2 and 3; vector bytes come from the memory model
// Notes:   Expected reads and vectors are queued and checked by a watcher
`timescale 1ns/100ps
`default_nettype none
module tb_prsr_top;
    import prsr_pkg::*;
    localparam int          WDO = 4;
    localparam int          SYS = 2;
    localparam logic [15:0] VEC = 16'h3C5A;
    logic          clock = 1'b0;
    logic          nrst, ext_reset_n, stop_instr, core_ei, core_di, core_irq_ack;
    logic          wdo_tick, wdt_timeout, wdt_irq_mode;
    logic [7:0]    gpio_in, gpio_wake_en, pm_data, rdata;
    prsr_bus_req_t bus_req;
    logic          core_reset, regfile_reset, stop_mode, pc_load, wdt_irq_req, pm_rd, irq;
    logic [15:0]   pc_value, pm_addr;
    logic [7:0]    q_rd[$];
    logic [15:0]   q_pc[$];
    logic          rd_seen = 1'b0;
    logic          rf;
    int            n_fail = 0;
    int            compares = 0;
    int            cycles = 0;
    int            seed = 32'hF5E2;
    int            n;

    always #2 clock = ~clock;

    prsr_top #(.GPIO_W(8), .WDO_CYCLES(WDO), .SYS_CYCLES(SYS), .SHORT_CYCLES(3)) uut (
        .clock, .nrst, .ext_reset_n, .stop_instr, .core_ei, .core_di, .core_irq_ack,
        .core_reset, .regfile_reset, .stop_mode, .pc_load, .pc_value, .wdt_irq_req,
        .pm_rd, .pm_addr, .pm_data, .wdo_tick, .wdt_timeout, .wdt_irq_mode,
        .gpio_in, .gpio_wake_en, .bus_req, .rdata, .irq
    );

    prsr_pm_model #(.VECTOR(VEC)) pm (.clock, .nrst, .pm_rd, .pm_addr, .pm_data);

    task automatic close_out();
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Watcher: read data one cycle after the strobe, vector on each load pulse
    always @(posedge clock) begin
        rd_seen <= bus_req.rd;
        cycles <= cycles + 1;
        if (rd_seen) chk(rdata, q_rd.pop_front());
        if (!rd_seen && nrst) chk(rdata, 8'h00);
        if (pc_load === 1'b1) chk(pc_value, q_pc.pop_front());
        if (cycles == 8000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
    endtask

    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: stop_instr <= 1'b1;
            1: core_ei <= 1'b1;
            2: core_di <= 1'b1;
            3: wdt_timeout <= 1'b1;
            default: core_irq_ack <= 1'b1;
        endcase
        @(posedge clock);
        {stop_instr, core_ei, core_di, wdt_timeout, core_irq_ack} <= 5'h00;
    endtask

    task automatic tick(input int k);
        repeat (k) begin
            repeat ({$random(seed)} % 3) @(posedge clock);
            @(posedge clock);
            wdo_tick <= 1'b1;
            @(posedge clock);
            wdo_tick <= 1'b0;
        end
    endtask

    task automatic wait_pc(output int cnt, output logic rfs);
        cnt = 0;
        rfs = 1'b0;
        do begin
            @(posedge clock);
            cnt++;
            rfs = rfs | regfile_reset;
        end while (pc_load !== 1'b1 && cnt < 300);
    endtask

    task automatic stop_wake(input logic by_wdt, input logic ime);
        int          cnt;
        logic        rfs;
        logic [7:0]  pin;
        pin = 8'h01 << ({$random(seed)} % 8);
        pulse(ime ? 1 : 2);
        rd(REG_CTRL, {7'h00, ime});
        pulse(3);
        repeat (3) @(posedge clock);
        chk(stop_mode, 1'b0);
        gpio_wake_en <= pin;
        pulse(0);
        repeat (2) @(posedge clock);
        chk(stop_mode, 1'b1);
        gpio_in <= gpio_in ^ ~pin;
        repeat (4) @(posedge clock);
        chk({core_reset, stop_mode}, 2'b01);
        q_pc.push_back(VEC);
        if (by_wdt) begin
            pulse(3);
        end else begin
            gpio_in <= gpio_in ^ pin;
        end
        tick(WDO - 1);
        repeat (20) @(posedge clock);
        chk({core_reset, wdt_irq_req}, 2'b10);
        tick(1);
        wait_pc(cnt, rfs);
        chk(cnt, SYS + 4);
        chk(rfs, 1'b0);
        chk(core_reset, 1'b0);
        chk(wdt_irq_req, by_wdt & ime & wdt_irq_mode);
        rd(REG_WDCTL, by_wdt ? 8'h03 : 8'h01);
        wr(REG_WDCTL, 8'h07);
        pulse(4);
        repeat (2) @(posedge clock);
        chk(wdt_irq_req, 1'b0);
    endtask

    initial begin
        nrst = 1'b0;
        ext_reset_n = 1'b1;
        {stop_instr, core_ei, core_di, wdt_timeout, core_irq_ack, wdo_tick} = 6'h00;
        wdt_irq_mode = 1'b1;
        gpio_wake_en = 8'h00;
        gpio_in = 8'($random(seed));
        bus_req = '0;
        q_pc.push_back(VEC);
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        wait_pc(n, rf);
        chk(n, 7);
        rd(REG_WDCTL, 8'h00);
        rd(REG_CTRL, 8'h00);
        rd(REG_INT_ENABLE, 8'h00);
        // Pin held low well past the short reset time-out
        q_pc.push_back(VEC);
        @(posedge clock);
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk({core_reset, regfile_reset}, 2'b11);
        repeat (20) @(posedge clock);
        chk(core_reset, 1'b1);
        ext_reset_n <= 1'b1;
        wait_pc(n, rf);
        chk(n, 5);
        rd(REG_WDCTL, 8'h04);
        wr(REG_WDCTL, 8'h07);
        rd(REG_WDCTL, 8'h00);
        stop_wake(1'b0, 1'b0);
        stop_wake(1'b1, 1'b1);
        stop_wake(1'b1, 1'b0);
        // Watchdog set to reset rather than interrupt: no request
        wdt_irq_mode <= 1'b0;
        stop_wake(1'b1, 1'b1);
        // Sticky status, mask, clear and unmapped read
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        rd(REG_INT_STATUS, 8'h07);
        wr(REG_INT_ENABLE, 8'h02);
        repeat (2) @(posedge clock);
        chk(irq, 1'b1);
        wr(REG_INT_CLEAR, 8'h02);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        rd(REG_INT_STATUS, 8'h05);
        rd(4'hF, 8'h00);
        repeat (3) @(posedge clock);
        chk(q_rd.size(), 16'h0000);
        chk(q_pc.size(), 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
